/* File: hw/epif_pkg.sv */
package epif_pkg;
    localparam int NCH = 2;
    localparam int AW = 8;
    localparam int DW = 8;
    // Register offsets.
    localparam logic [7:0] OFS_FLAG = 8'h00;
    localparam logic [7:0] OFS_MODE = 8'h01;
    localparam logic [7:0] OFS_EDGE = 8'h02;
    localparam logic [7:0] OFS_EVT = 8'h03;
    localparam logic [7:0] OFS_MASK = 8'h04;
    // Field positions inside each register.
    localparam int BIT_CHAN0 = 0;
    localparam int BIT_CHAN1 = 1;
    // Reset values.
    localparam logic [1:0] RST_FLAG = 2'h0;
    localparam logic [1:0] RST_MODE = 2'h0;
    localparam logic [1:0] RST_EDGE = 2'h0;
    localparam logic [1:0] RST_EVT = 2'h0;
    localparam logic [1:0] RST_MASK = 2'h0;
    localparam logic [1:0] RST_PIN = 2'h3;
    localparam logic [7:0] RD_ZERO = 8'h00;
endpackage

/* File: hw/epif_flag_if.sv */
`timescale 1ns/10ps
interface epif_flag_if;
    import epif_pkg::*;
    logic [NCH-1:0] pin_lvl;
    logic [NCH-1:0] edge_mode;
    logic [NCH-1:0] rise_sel;
    logic [NCH-1:0] sw_clear;
    logic [NCH-1:0] accept;
    logic [NCH-1:0] flag;
    logic [NCH-1:0] set_evt;
    modport ctrl (output pin_lvl, edge_mode, rise_sel, sw_clear, accept, input flag, set_evt);
    modport unit (input pin_lvl, edge_mode, rise_sel, sw_clear, accept, output flag, set_evt);
endinterface

/* File: hw/epif_flag_unit.sv */
`timescale 1ns/10ps
module epif_flag_unit (
    // Clock and reset.
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Control and flags.
    epif_flag_if.unit fl
);
    import epif_pkg::*;

    logic [NCH-1:0] prev_reg;
    logic [NCH-1:0] flag_reg;
    logic [NCH-1:0] edge_hit;
    logic [NCH-1:0] flag_next;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            edge_hit[i] = fl.rise_sel[i] ? (~prev_reg[i] & fl.pin_lvl[i]) : (prev_reg[i] & ~fl.pin_lvl[i]);
            if (!fl.edge_mode[i]) begin
                flag_next[i] = ~fl.pin_lvl[i];
            end else if (edge_hit[i]) begin
                flag_next[i] = 1'b1;
            end else if (fl.sw_clear[i] || fl.accept[i]) begin
                flag_next[i] = 1'b0;
            end else begin
                flag_next[i] = flag_reg[i];
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prev_reg <= RST_PIN;
        end else begin
            prev_reg <= fl.pin_lvl;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            flag_reg <= RST_FLAG;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign fl.flag = flag_reg;
    assign fl.set_evt = flag_next & ~flag_reg;
endmodule

/* File: hw/epif_top.sv */
// Functional notes
// - Level mode: flag reads 1 while the channel request pin is low.
// - Level mode: flag returns to 0 once the pin goes high, no software needed.
// - Edge mode: chosen pin edge sets the flag, which stays set afterwards.
// - Edge mode: writing 0 after reading the flag as 1 clears it.
// - Edge mode: CPU accepting the channel interrupt clears its flag.
// - Channel one flag at bit 1, channel zero at bit 0, reset 0, R/W.
`timescale 1ns/10ps
module epif_top (
    // Clock and reset.
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // External request pins.
    input wire logic i_chan0_request_pin,
    input wire logic i_chan1_request_pin,
    // Interrupt acceptance from the CPU, one pulse per channel.
    input wire logic [epif_pkg::NCH-1:0] i_accept,
    // Register port.
    input wire logic [epif_pkg::AW-1:0] i_addr,
    input wire logic [epif_pkg::DW-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [epif_pkg::DW-1:0] o_rdata,
    // Interrupt and flags.
    output logic o_irq,
    output logic [epif_pkg::NCH-1:0] o_request_flags
);
    import epif_pkg::*;

    logic [NCH-1:0] sync1_reg;
    logic [NCH-1:0] sync2_reg;
    logic [NCH-1:0] mode_reg;
    logic [NCH-1:0] edge_reg;
    logic [NCH-1:0] evt_reg;
    logic [NCH-1:0] mask_reg;
    logic [NCH-1:0] armed_reg;
    logic [DW-1:0] rdata_reg;
    logic [DW-1:0] rdata_next;
    logic [NCH-1:0] wr_bits;

    epif_flag_if fl ();

    function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] ofs);
        hit = (a == ofs);
    endfunction

    function automatic logic [DW-1:0] widen(input logic [NCH-1:0] v);
        widen = {{(DW-NCH){1'b0}}, v};
    endfunction

    assign wr_bits = i_wdata[NCH-1:0];

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; the first stage feeds only the second.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync1_reg <= RST_PIN;
            sync2_reg <= RST_PIN;
        end else begin
            sync1_reg <= {i_chan1_request_pin, i_chan0_request_pin};
            sync2_reg <= sync1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mode_reg <= RST_MODE;
            edge_reg <= RST_EDGE;
            mask_reg <= RST_MASK;
        end else if (i_wr) begin
            if (hit(i_addr, OFS_MODE)) begin
                mode_reg <= wr_bits;
            end
            if (hit(i_addr, OFS_EDGE)) begin
                edge_reg <= wr_bits;
            end
            if (hit(i_addr, OFS_MASK)) begin
                mask_reg <= wr_bits;
            end
        end
    end

    // A read that sees a flag at 1 arms that channel for a clear; the next flag write disarms.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            armed_reg <= '0;
        end else if (i_wr && hit(i_addr, OFS_FLAG)) begin
            armed_reg <= '0;
        end else if (i_rd && hit(i_addr, OFS_FLAG)) begin
            armed_reg <= armed_reg | fl.flag;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flag unit connection.
    assign fl.pin_lvl = sync2_reg;
    assign fl.edge_mode = mode_reg;
    assign fl.rise_sel = edge_reg;
    assign fl.accept = i_accept & mode_reg;
    // Only a 0 written to an armed bit clears; 1s and unarmed 0s are ignored.
    assign fl.sw_clear = {NCH{i_wr && hit(i_addr, OFS_FLAG)}} & ~wr_bits & armed_reg;

    epif_flag_unit u_flag (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .fl(fl)
    );

    assign o_request_flags = fl.flag;

    ////////////////////////////////////////////////////////////////////////////
    // Sticky event status, write one to clear; a new event wins over the clear.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            evt_reg <= RST_EVT;
        end else begin
            if (i_wr && hit(i_addr, OFS_EVT)) begin
                evt_reg <= (evt_reg & ~wr_bits) | fl.set_evt;
            end else begin
                evt_reg <= evt_reg | fl.set_evt;
            end
        end
    end

    assign o_irq = |(evt_reg & mask_reg);

    ////////////////////////////////////////////////////////////////////////////
    // Read data, valid the cycle after the read strobe only.
    always_comb begin
        rdata_next = RD_ZERO;
        if (i_rd) begin
            unique case (1'b1)
                hit(i_addr, OFS_FLAG): rdata_next = widen(fl.flag);
                hit(i_addr, OFS_MODE): rdata_next = widen(mode_reg);
                hit(i_addr, OFS_EDGE): rdata_next = widen(edge_reg);
                hit(i_addr, OFS_EVT): rdata_next = widen(evt_reg);
                hit(i_addr, OFS_MASK): rdata_next = widen(mask_reg);
                default: rdata_next = RD_ZERO;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_reg <= RD_ZERO;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign o_rdata = rdata_reg;
endmodule

/* File: test/epif_pin_src.sv */
`timescale 1ns/10ps
module epif_pin_src (
    // Clock and bench controls.
    input wire logic i_clk_sys,
    input wire logic [1:0] i_lvl,
    input wire logic i_slow,
    // Request pins, driven at all times.
    output logic [1:0] o_pins
);
    logic [1:0] dly_reg = 2'h3;
    // A slow source shows each new level one cycle late.
    always_ff @(posedge i_clk_sys) begin
        dly_reg <= i_lvl;
    end
    assign o_pins = i_slow ? dly_reg : i_lvl;
endmodule

/* File: test/epif_props.sv */
`timescale 1ns/10ps
module epif_props (
    // Clock, reset and pins.
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_chan0_request_pin,
    input wire logic i_chan1_request_pin,
    input wire logic [1:0] i_accept,
    // Register port.
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    // Outputs.
    input wire logic o_irq,
    input wire logic [1:0] o_request_flags
);
    import epif_pkg::*;
    logic [1:0] md_reg;
    logic [1:0] mk_reg;
    logic pin_reg;
    logic [2:0] qt_reg;
    wire fw = i_wr && i_addr == OFS_FLAG;
    wire em = md_reg[0];
    wire q = &qt_reg;
    // Mirrors of mode and mask, and how long the channel 0 pin has been still.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            md_reg <= 2'h0;
            mk_reg <= 2'h0;
        end else if (i_wr && i_addr == OFS_MODE) begin
            md_reg <= i_wdata[1:0];
        end else if (i_wr && i_addr == OFS_MASK) begin
            mk_reg <= i_wdata[1:0];
        end
    end
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_reg <= 1'b1;
            qt_reg <= 3'h0;
        end else begin
            pin_reg <= i_chan0_request_pin;
            qt_reg <= (pin_reg != i_chan0_request_pin) ? 3'h0 : qt_reg + {2'h0, ~&qt_reg};
        end
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    a_rd_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("rdata not idle");
    a_rd_flag_data: assert property ($past(i_rd) && $past(i_addr) == OFS_FLAG
        |-> o_rdata == {6'h00, $past(o_request_flags)}) else $error("flag read wrong");
    a_level_follow: assert property (md_reg == 2'h0 && $past(md_reg, 3) == 2'h0
        |-> o_request_flags == ~$past({i_chan1_request_pin, i_chan0_request_pin}, 3)) else $error("level flag");
    a_accept_clear: assert property (em && $past(em) && q && $past(i_accept[0])
        |-> !o_request_flags[0]) else $error("accept kept flag");
    a_armed_clear: assert property (em && q && $past(fw) && !$past(i_wdata[0]) && $past(i_rd, 2)
        && $past(i_addr, 2) == OFS_FLAG && $past(o_request_flags[0], 2) |-> !o_request_flags[0]) else $error("no clear");
    a_unarmed_keep: assert property (em && q && $past(fw) && $past(fw, 2) && $past(o_request_flags[0])
        |-> o_request_flags[0]) else $error("unarmed clear");
    a_edge_hold: assert property (em && $past(em) && q && $past(o_request_flags[0]) && !$past(fw)
        && !$past(i_accept[0]) |-> o_request_flags[0]) else $error("flag lost");
    a_irq_masked: assert property (mk_reg == 2'h0 |-> !o_irq) else $error("irq while masked");
    c_accept: cover property (em && $past(i_accept[0]));
    c_clear: cover property ($past(fw) && $fell(o_request_flags[0]));
    c_irq: cover property (o_irq);
endmodule
bind epif_top epif_props epif_props_inst (.*);

/* File: test/tb_epif_top.sv */
`timescale 1ns/10ps
module tb_epif_top;
    import epif_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_rst_n = 1'b0;
    logic [1:0] i_accept = 2'h0;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [1:0] lvl = 2'h3;
    logic slow = 1'b0;
    logic rd_seen = 1'b0;
    logic i_chan0_request_pin;
    logic i_chan1_request_pin;
    logic [7:0] o_rdata;
    logic o_irq;
    logic [1:0] o_request_flags;
    logic [7:0] exp_q[$];
    int n_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    int seed = 32'h1202_63d3;
    epif_pin_src epif_pin_src_inst (.i_clk_sys(i_clk_sys), .i_lvl(lvl), .i_slow(slow),
        .o_pins({i_chan1_request_pin, i_chan0_request_pin}));
    epif_top epif_top_inst (.*);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One bus cycle; for a read the data argument is the expected answer.
    task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        i_wr <= w;
        i_rd <= r;
        i_addr <= a;
        i_wdata <= d;
        if (r) exp_q.push_back(d);
        @(posedge i_clk_sys);
    endtask
    task automatic idle(input int n);
        repeat (n) bus(1'b0, 1'b0, 8'h00, 8'h00);
    endtask
    task automatic stop_test;
        if (n_errors == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial forever #2.5 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) rd_seen <= i_rd;
    always @(negedge i_clk_sys) begin
        if (rd_seen) chk(o_rdata, exp_q.pop_front());
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            stop_test();
        end
    end
    initial begin
        repeat (6) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        @(posedge i_clk_sys);
        for (int a = 0; a < 8; a++) bus(1'b0, 1'b1, 8'(a), 8'h00);
        bus(1'b1, 1'b0, 8'h07, 8'($random(seed)));
        lvl <= 2'h2;
        idle(6);
        bus(1'b1, 1'b0, OFS_FLAG, 8'h00);
        bus(1'b0, 1'b1, OFS_FLAG, 8'h01);
        lvl <= 2'h1;
        idle(6);
        bus(1'b0, 1'b1, OFS_FLAG, 8'h02);
        lvl <= 2'h3;
        slow <= 1'b1;
        idle(6);
        bus(1'b1, 1'b0, OFS_MODE, 8'h03);
        for (int e = 0; e < 2; e++) begin
            bus(1'b1, 1'b0, OFS_EDGE, e ? 8'h03 : 8'h00);
            lvl <= 2'h0;
            idle(10);
            bus(1'b0, 1'b1, OFS_FLAG, e ? 8'h00 : 8'h03);
            lvl <= 2'h3;
            idle(10);
            bus(1'b0, 1'b1, OFS_FLAG, 8'h03);
            bus(1'b1, 1'b0, OFS_FLAG, 8'($random(seed)) | 8'h03);
            bus(1'b1, 1'b0, OFS_FLAG, 8'h00);
            bus(1'b0, 1'b1, OFS_FLAG, 8'h03);
            if (e == 0) bus(1'b1, 1'b0, OFS_FLAG, 8'h00);
        end
        bus(1'b1, 1'b0, OFS_FLAG, 8'h00);
        bus(1'b0, 1'b1, OFS_FLAG, 8'h00);
        bus(1'b1, 1'b0, OFS_EDGE, 8'h00);
        lvl <= 2'h0;
        idle(12);
        for (int c = 0; c < 2; c++) begin
            i_accept <= 2'(1 << c);
            idle(1);
            i_accept <= 2'h0;
            bus(1'b0, 1'b1, OFS_FLAG, c ? 8'h00 : 8'h02);
        end
        bus(1'b0, 1'b1, OFS_EVT, 8'h03);
        bus(1'b1, 1'b0, OFS_MASK, 8'h01);
        idle(1);
        chk({7'h00, o_irq}, 8'h01);
        bus(1'b1, 1'b0, OFS_EVT, 8'h01);
        idle(1);
        chk({7'h00, o_irq}, 8'h00);
        bus(1'b0, 1'b1, OFS_EVT, 8'h02);
        idle(3);
        stop_test();
    end
endmodule
